// ---- logic/flash_sec_pkg.sv ----
package flash_sec_pkg;

   // register map
   localparam logic [15:0] OPTION_STATE_ADDR = 16'h1820;
   localparam logic [15:0] CONFIG_ADDR       = 16'h1823;
   localparam logic [15:0] PROTECT_ADDR      = 16'h1824;

   // backdoor comparison key window
   localparam logic [15:0] KEY_BASE_ADDR     = 16'hFFB0;
   localparam int          KEY_BYTES         = 8;
   localparam logic [15:0] KEY_ADDR_MASK     = 16'hFFF8;

   // vector block, which also holds the key
   localparam logic [15:0] VEC_REGION_MASK   = 16'hFE00;
   localparam logic [15:0] VEC_REGION_BASE   = 16'hFE00;
   localparam int          PROT_VEC_BIT      = 0;

   // option byte fields
   localparam int          SEC_LSB           = 0;
   localparam int          SEC_MSB           = 1;
   localparam int          REDIR_DIS_BIT     = 6;
   localparam int          BACKDOOR_EN_BIT   = 7;
   localparam logic [1:0]  SEC_UNSECURED     = 2'h2;

   // config register fields
   localparam int          KEY_ACCESS_BIT    = 5;
   localparam logic [7:0]  CONFIG_RW_MASK    = 8'hE0;
   localparam logic [7:0]  CONFIG_RESET      = 8'h00;
   localparam logic [7:0]  READ_UNMAPPED     = 8'h00;

   localparam logic [1:0]  PIN_SYNC_RESET    = 2'h3;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
      logic        from_ram;
      logic        from_bdm;
   } bus_req_s;

   typedef struct packed {
      logic        start;
      logic        prot_err;
      logic [15:0] addr;
      logic [7:0]  data;
   } flash_cmd_s;

   typedef enum logic [1:0] {
      KEY_IDLE  = 2'b00,
      KEY_ENTRY = 2'b01,
      KEY_FULL  = 2'b10
   } key_state_e;

endpackage

// ---- logic/key_capture.sv ----
`timescale 1ns/10ps
module key_capture
   import flash_sec_pkg::*;
#(
   parameter int NBYTES = KEY_BYTES
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  clear,
   input  wire logic                  wr_en,
   input  wire logic [2:0]            wr_idx,
   input  wire logic [7:0]            wr_data,
   input  wire logic [NBYTES*8-1:0]   stored_key,
   output logic                       all_written,
   output logic                       match
);

   logic [7:0] key_reg [NBYTES];
   logic [2:0] next_idx_reg;
   logic       order_ok_reg;
   logic       full_reg;
   logic       match_reg;
   logic       eq_all;

   always_comb begin
      eq_all = 1'b1;
      for (int i = 0; i < NBYTES; i++) begin
         if (key_reg[i] != stored_key[i*8 +: 8]) begin
            eq_all = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < NBYTES; i++) begin
            key_reg[i] <= 8'h00;
         end
      end else if (wr_en) begin
         key_reg[wr_idx] <= wr_data;
      end
   end

   // out of order writes spoil the attempt until cleared
   always_ff @(posedge clk) begin
      if (!rst_n || clear) begin
         next_idx_reg <= 3'h0;
         order_ok_reg <= 1'b1;
         full_reg     <= 1'b0;
      end else if (wr_en) begin
         if (wr_idx != next_idx_reg || full_reg) begin
            order_ok_reg <= 1'b0;
         end
         next_idx_reg <= next_idx_reg + 3'h1;
         if (wr_idx == 3'(NBYTES - 1)) begin
            full_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || clear) begin
         match_reg <= 1'b0;
      end else begin
         match_reg <= eq_all && order_ok_reg && full_reg;
      end
   end

   assign all_written = full_reg;
   assign match       = match_reg;

endmodule

// ---- logic/flash_security.sv ----
// How it works
// [RULE_01] only state 10 counts as unsecured
// [RULE_02] debug module cannot enable while secure
// [RULE_03] secure: background mode only via reset pin
// [RULE_04] backdoor disabled: key attempts ignored
// [RULE_05] key access set: key addresses capture key
// [RULE_06] key access clear: key address starts command
// [RULE_07] key access set: store reads flagged invalid
// [RULE_08] software writes key ascending, never back-to-back
// [RULE_09] clearing key access with match unsecures
// [RULE_10] only RAM-executed key writes count
// [RULE_11] key shares protected vector block
// [RULE_12] erased blank check unsecures until reset
// [RULE_13] protect register written only by debug
// [RULE_14] reset copies protect byte into register
// [RULE_15] redirection disable bit turns redirection off
// [RULE_16] config bits 7..5 rw, rest read zero
// [RULE_17] secure blocks memory access from unsecured source
// [RULE_18] reset loads security and redirection from option
// [RULE_19] mismatched key leaves security unchanged
`timescale 1ns/10ps
module flash_security
   import flash_sec_pkg::*;
(
   input  wire logic                    CLK,
   input  wire logic                    RST_N,
   input  wire bus_req_s                BUS_REQ,
   input  wire logic [7:0]              NV_OPTION,
   input  wire logic [7:0]              NV_PROTECT,
   input  wire logic [KEY_BYTES*8-1:0]  NV_KEY,
   input  wire logic                    BLANK_CHECK_DONE,
   input  wire logic                    BLANK_CHECK_ERASED,
   input  wire logic                    BACKGROUND_MODE_SELECT_PIN_PIN,
   input  wire logic                    DEBUG_EN_REQ,
   input  wire logic                    BDM_ENTER_REQ,
   output logic [7:0]                   REG_RDATA,
   output flash_cmd_s                   FLASH_CMD,
   output logic                         SECURE,
   output logic                         DEBUG_ENABLED,
   output logic                         BDM_ACTIVE,
   output logic                         MEM_ACCESS_BLOCK,
   output logic                         FLASH_READ_INVALID,
   output logic                         VECTOR_REDIRECT_EN,
   output logic [7:0]                   PROTECT_BYTE
);

   logic [1:0]  sec_reg;
   logic        redir_dis_reg;
   logic        backdoor_en_reg;
   logic [7:0]  opt_rest_reg;
   logic [7:0]  config_reg;
   logic [7:0]  protect_reg;
   logic [7:0]  rdata_reg;
   flash_cmd_s  cmd_reg;
   logic        pin_meta_reg;
   logic        pin_sync_reg;
   logic        rst_seen_reg;
   logic        bdm_active_reg;
   logic        debug_en_reg;
   key_state_e  key_state_reg;
   key_state_e  key_state_next;

   logic        secure;
   logic        key_access;
   logic        is_key_addr;
   logic        in_vec_region;
   logic        vec_protected;
   logic        wr_config;
   logic        key_access_falling;
   logic        key_wr_ok;
   logic        cmd_wr;
   logic        key_full;
   logic        key_match;
   logic        unlock_key;
   logic        unlock_blank;
   logic [7:0]  opt_view;
   logic [7:0]  rd_mux;
   logic        wr_protect;
   logic        vec_hit;
   logic        unlock;
   logic        strap_low;

   // [RULE_01] only one code unlocks
   assign secure = (sec_reg != SEC_UNSECURED);

   assign key_access    = config_reg[KEY_ACCESS_BIT];
   assign is_key_addr   = ((BUS_REQ.addr & KEY_ADDR_MASK) == KEY_BASE_ADDR);
   assign in_vec_region = ((BUS_REQ.addr & VEC_REGION_MASK)
                           == VEC_REGION_BASE);
   assign vec_protected = ~protect_reg[PROT_VEC_BIT];
   assign vec_hit       = in_vec_region && vec_protected;
   assign wr_config     = BUS_REQ.wr && (BUS_REQ.addr == CONFIG_ADDR);
   assign wr_protect    = BUS_REQ.wr && BUS_REQ.from_bdm
                          && (BUS_REQ.addr == PROTECT_ADDR);
   // compare fires only on a one-to-zero write of the access bit
   assign key_access_falling = wr_config && key_access
                               && !BUS_REQ.wdata[KEY_ACCESS_BIT];

   // [RULE_05] key write path when access bit set
   // [RULE_10] debug-issued key writes are dropped
   // [RULE_04] no capture with backdoor disabled
   // [RULE_08] order checked, spacing left to software
   assign key_wr_ok = BUS_REQ.wr && is_key_addr && key_access
                      && BUS_REQ.from_ram && !BUS_REQ.from_bdm
                      && backdoor_en_reg;

   // [RULE_06] key address starts command otherwise
   assign cmd_wr = BUS_REQ.wr && is_key_addr && !key_access;

   // [RULE_09] compare on clearing key access
   // [RULE_19] mismatch falls through unchanged
   assign unlock_key   = key_access_falling && backdoor_en_reg
                         && key_match && (key_state_reg == KEY_FULL);
   // [RULE_12] blank erased store unsecures
   assign unlock_blank = BLANK_CHECK_DONE && BLANK_CHECK_ERASED;
   assign unlock       = unlock_key || unlock_blank;

   key_capture #(
      .NBYTES      (KEY_BYTES)
   ) u_key (
      .clk         (CLK),
      .rst_n       (RST_N),
      .clear       (key_access_falling),
      .wr_en       (key_wr_ok),
      .wr_idx      (BUS_REQ.addr[2:0]),
      .wr_data     (BUS_REQ.wdata),
      .stored_key  (NV_KEY),
      .all_written (key_full),
      .match       (key_match)
   );

   // the match flag lags the last byte by one cycle, so a clear that
   // lands right behind it still sees the flag low and does not unlock
   always_comb begin
      key_state_next = key_state_reg;
      case (key_state_reg)
         KEY_IDLE: begin
            if (key_wr_ok) begin
               key_state_next = KEY_ENTRY;
            end
         end
         KEY_ENTRY: begin
            if (key_access_falling) begin
               key_state_next = KEY_IDLE;
            end else if (key_full) begin
               key_state_next = KEY_FULL;
            end
         end
         KEY_FULL: begin
            if (key_access_falling) begin
               key_state_next = KEY_IDLE;
            end
         end
         default: begin
            key_state_next = KEY_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         key_state_reg <= KEY_IDLE;
      end else begin
         key_state_reg <= key_state_next;
      end
   end

   // [RULE_18] security field reloads while reset held
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         sec_reg <= NV_OPTION[SEC_MSB:SEC_LSB];
      end else if (unlock) begin
         // sticks until next reset
         sec_reg <= SEC_UNSECURED;
      end
   end

   // [RULE_18] other option fields change only in reset
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         redir_dis_reg   <= NV_OPTION[REDIR_DIS_BIT];
         backdoor_en_reg <= NV_OPTION[BACKDOOR_EN_BIT];
         opt_rest_reg    <= NV_OPTION;
      end
   end

   // [RULE_16] only upper three bits stored
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         config_reg <= CONFIG_RESET;
      end else if (wr_config) begin
         config_reg <= BUS_REQ.wdata & CONFIG_RW_MASK;
      end
   end

   // [RULE_14] protect byte copied during reset
   // [RULE_13] debug-only writes
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         protect_reg <= NV_PROTECT;
      end else if (wr_protect) begin
         protect_reg <= BUS_REQ.wdata;
      end
   end

   always_comb begin
      opt_view = opt_rest_reg;
      opt_view[SEC_MSB:SEC_LSB] = sec_reg;
      opt_view[REDIR_DIS_BIT]   = redir_dis_reg;
      opt_view[BACKDOOR_EN_BIT] = backdoor_en_reg;
   end

   // register read decode, unmapped addresses read zero
   always_comb begin
      rd_mux = READ_UNMAPPED;
      if (BUS_REQ.addr == OPTION_STATE_ADDR) begin
         rd_mux = opt_view;
      end else if (BUS_REQ.addr == CONFIG_ADDR) begin
         rd_mux = config_reg & CONFIG_RW_MASK;
      end else if (BUS_REQ.addr == PROTECT_ADDR) begin
         rd_mux = protect_reg;
      end
   end

   // read data one cycle after the strobe, held until next read
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         rdata_reg <= READ_UNMAPPED;
      end else if (BUS_REQ.rd) begin
         rdata_reg <= rd_mux;
      end
   end

   // [RULE_11] key lies inside protected vector block
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         cmd_reg <= '0;
      end else begin
         cmd_reg.start    <= cmd_wr && !vec_hit;
         cmd_reg.prot_err <= cmd_wr && vec_hit;
         if (cmd_wr) begin
            cmd_reg.addr <= BUS_REQ.addr;
            cmd_reg.data <= BUS_REQ.wdata;
         end
      end
   end

   // pin crosses in from outside, two stages first; left free of
   // reset so the strap level is already settled when reset lifts
   always_ff @(posedge CLK) begin
      pin_meta_reg <= BACKGROUND_MODE_SELECT_PIN_PIN;
   end

   always_ff @(posedge CLK) begin
      pin_sync_reg <= pin_meta_reg;
   end

   // strap taken on the first edge after release; the synchroniser
   // runs through reset, so the pin must be low two edges before it
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         rst_seen_reg <= 1'b0;
      end else begin
         rst_seen_reg <= 1'b1;
      end
   end

   assign strap_low = !rst_seen_reg && !pin_sync_reg;

   // [RULE_03] strap is the only entry while secure
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         bdm_active_reg <= 1'b0;
      end else if (strap_low) begin
         bdm_active_reg <= 1'b1;
      end else if (BDM_ENTER_REQ && !secure) begin
         bdm_active_reg <= 1'b1;
      end
   end

   // [RULE_02] enable refused while secure
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         debug_en_reg <= 1'b0;
      end else begin
         debug_en_reg <= DEBUG_EN_REQ && !secure;
      end
   end

   assign REG_RDATA          = rdata_reg;
   assign FLASH_CMD          = cmd_reg;
   assign SECURE             = secure;
   assign DEBUG_ENABLED      = debug_en_reg;
   assign BDM_ACTIVE         = bdm_active_reg;
   // combinational so the bus can refuse in the same cycle
   // [RULE_17] unsecured source blocked while secure
   assign MEM_ACCESS_BLOCK   = secure && BUS_REQ.from_bdm
                               && (BUS_REQ.rd || BUS_REQ.wr);
   // [RULE_07] reads unreliable during key entry
   assign FLASH_READ_INVALID = key_access;
   // [RULE_15] bit set turns redirection off
   assign VECTOR_REDIRECT_EN = ~redir_dis_reg;
   assign PROTECT_BYTE       = protect_reg;

endmodule

// ---- verif/flash_security_monitor.sv ----
`timescale 1ns/10ps
module flash_security_monitor
   import flash_sec_pkg::*;
(
   input wire logic                   CLK,
   input wire logic                   RST_N,
   input wire bus_req_s               BUS_REQ,
   input wire logic [7:0]             NV_OPTION,
   input wire logic [7:0]             NV_PROTECT,
   input wire logic [KEY_BYTES*8-1:0] NV_KEY,
   input wire logic                   BLANK_CHECK_DONE,
   input wire logic                   BLANK_CHECK_ERASED,
   input wire logic                   BACKGROUND_MODE_SELECT_PIN_PIN,
   input wire logic                   DEBUG_EN_REQ,
   input wire logic                   BDM_ENTER_REQ,
   input wire logic [7:0]             REG_RDATA,
   input wire flash_cmd_s             FLASH_CMD,
   input wire logic                   SECURE,
   input wire logic                   DEBUG_ENABLED,
   input wire logic                   BDM_ACTIVE,
   input wire logic                   MEM_ACCESS_BLOCK,
   input wire logic                   FLASH_READ_INVALID,
   input wire logic                   VECTOR_REDIRECT_EN,
   input wire logic [7:0]             PROTECT_BYTE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);

   wire logic key_wr = BUS_REQ.wr &&
      ((BUS_REQ.addr & KEY_ADDR_MASK) == KEY_BASE_ADDR);
   wire logic key_clr = BUS_REQ.wr && BUS_REQ.addr == CONFIG_ADDR &&
      !BUS_REQ.wdata[KEY_ACCESS_BIT] && FLASH_READ_INVALID;
   wire logic blank_ok = BLANK_CHECK_DONE && BLANK_CHECK_ERASED;

   sequence s_blank_ok;
      BLANK_CHECK_DONE && BLANK_CHECK_ERASED;
   endsequence
   sequence s_unlock;
      SECURE ##1 !SECURE;
   endsequence

   a_reset_sec: assert property (
      $rose(RST_N) |-> SECURE ==
      ($past(NV_OPTION[SEC_MSB:SEC_LSB]) != SEC_UNSECURED))
      else $error("security state not loaded at reset");
   a_reset_prot: assert property (
      $rose(RST_N) |-> PROTECT_BYTE == $past(NV_PROTECT) &&
      VECTOR_REDIRECT_EN == !$past(NV_OPTION[REDIR_DIS_BIT]))
      else $error("protect or redirect not loaded at reset");
   a_debug_gate: assert property (
      DEBUG_ENABLED |-> $past(DEBUG_EN_REQ) && !$past(SECURE))
      else $error("debug enabled while secure");
   a_bdm_entry: assert property (
      $rose(BDM_ACTIVE) && SECURE |-> !$past(RST_N, 2))
      else $error("background mode entered while secure");
   a_mem_block: assert property (
      MEM_ACCESS_BLOCK == (SECURE && BUS_REQ.from_bdm &&
      (BUS_REQ.rd || BUS_REQ.wr)))
      else $error("memory block flag wrong");
   a_key_no_cmd: assert property (
      key_wr && FLASH_READ_INVALID |=>
      !FLASH_CMD.start && !FLASH_CMD.prot_err)
      else $error("key write started a command");
   a_cmd_start: assert property (
      key_wr && !FLASH_READ_INVALID |=>
      FLASH_CMD.start == $past(PROTECT_BYTE[PROT_VEC_BIT]) &&
      FLASH_CMD.prot_err == !$past(PROTECT_BYTE[PROT_VEC_BIT]) &&
      FLASH_CMD.data == $past(BUS_REQ.wdata))
      else $error("command start wrong");
   a_blank_unsec: assert property (
      s_blank_ok |=> !SECURE)
      else $error("blank check did not unsecure");
   a_unsec_hold: assert property (
      !SECURE |=> !SECURE)
      else $error("security came back before reset");
   a_fall_cause: assert property (
      s_unlock |-> $past(key_clr || blank_ok))
      else $error("security cleared without cause");
   a_protect_write: assert property (
      !$stable(PROTECT_BYTE) |-> $past(BUS_REQ.wr &&
      BUS_REQ.from_bdm && BUS_REQ.addr == PROTECT_ADDR))
      else $error("protect changed without debug write");
   a_cfg_read: assert property (
      BUS_REQ.rd && BUS_REQ.addr == CONFIG_ADDR |=>
      REG_RDATA[4:0] == 5'h00)
      else $error("config low bits not zero");
endmodule

bind flash_security flash_security_monitor flash_security_monitor_inst (.*);

// ---- verif/cpu_bus_model.sv ----
`timescale 1ns/10ps
module cpu_bus_model
   import flash_sec_pkg::*;
(
   input  wire logic clk,
   output bus_req_s  req
);
   initial req = '0;

   // one access, released with an idle cycle after it
   task automatic access(input logic [15:0] a, input logic [7:0] d,
                         input logic w, input logic bdm);
      @(negedge clk);
      req = '{a, d, w, !w, !bdm, bdm};
      @(negedge clk);
      req = '{~a, ~d, 1'b0, 1'b0, 1'b0, 1'b0};
   endtask

   task automatic send_key(input logic [63:0] k, input logic bdm);
      for (int i = 0; i < KEY_BYTES; i++) begin
         access(KEY_BASE_ADDR + 16'(i), k[8*i+:8], 1'b1, bdm);
      end
   endtask
endmodule

// ---- verif/flash_security_bench.sv ----
`timescale 1ns/10ps
module flash_security_bench;
   import flash_sec_pkg::*;
   localparam logic [63:0] KEY = 64'h0123456789ABCDEF;
   logic        CLK = 1'b0;
   logic        RST_N = 1'b0;
   bus_req_s    bus_req;
   logic [7:0]  nv_opt = 8'h80;
   logic [7:0]  nv_prot = 8'h01;
   logic        blank_done = 1'b0;
   logic        blank_erased = 1'b0;
   logic        pin = 1'b1;
   logic        dbg_req = 1'b0;
   logic        bdm_req = 1'b0;
   logic [7:0]  rdata;
   flash_cmd_s  cmd;
   logic        secure, dbg_en, bdm_act, blk, rd_inv, redir;
   logic [7:0]  prot;
   int          fail_count = 0;
   int          total_checks = 0;

   always #5 CLK = ~CLK;

   cpu_bus_model cpu_bus_model_inst (.clk(CLK), .req(bus_req));

   flash_security flash_security_inst (
      .CLK(CLK), .RST_N(RST_N), .BUS_REQ(bus_req),
      .NV_OPTION(nv_opt), .NV_PROTECT(nv_prot), .NV_KEY(KEY),
      .BLANK_CHECK_DONE(blank_done), .BLANK_CHECK_ERASED(blank_erased),
      .BACKGROUND_MODE_SELECT_PIN_PIN(pin), .DEBUG_EN_REQ(dbg_req), .BDM_ENTER_REQ(bdm_req),
      .REG_RDATA(rdata), .FLASH_CMD(cmd), .SECURE(secure),
      .DEBUG_ENABLED(dbg_en), .BDM_ACTIVE(bdm_act),
      .MEM_ACCESS_BLOCK(blk), .FLASH_READ_INVALID(rd_inv),
      .VECTOR_REDIRECT_EN(redir), .PROTECT_BYTE(prot));

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d,
                     input logic bdm);
      cpu_bus_model_inst.access(a, d, 1'b1, bdm);
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
      cpu_bus_model_inst.access(a, 8'h00, 1'b0, 1'b0);
      check(rdata, exp);
   endtask

   // pin set to its strap level with reset so the synchroniser has settled
   task automatic do_reset(input logic [7:0] opt, input logic p);
      @(negedge CLK);
      RST_N = 1'b0;
      nv_opt = opt;
      pin = p;
      repeat (8) @(negedge CLK);
      RST_N = 1'b1;
      @(negedge CLK);
      pin = 1'b1;
   endtask

   // match is registered, so three idle cycles before clearing
   task automatic try_key(input logic [63:0] k, input logic bdm);
      wr(CONFIG_ADDR, 8'h20, 1'b0);
      check(rd_inv, 8'h01);
      cpu_bus_model_inst.send_key(k, bdm);
      check({cmd.start, cmd.prot_err}, 8'h00);
      repeat (2) @(negedge CLK);
      wr(CONFIG_ADDR, 8'h00, 1'b0);
   endtask

   task automatic blank(input logic erased);
      @(negedge CLK);
      blank_done = 1'b1;
      blank_erased = erased;
      @(negedge CLK);
      blank_done = 1'b0;
   endtask

   initial begin
      repeat (20000) @(posedge CLK);
      fail_count++;
      end_of_test();
   end

   initial begin
      for (int i = 0; i < 4; i++) begin
         do_reset({1'b0, i[0], 4'h0, i[1:0]}, 1'b1);
         check(secure, 8'(i != 2));
         check(redir, 8'(!i[0]));
         rd_chk(OPTION_STATE_ADDR, {1'b0, i[0], 4'h0, i[1:0]});
      end
      $display("test decode done");
      do_reset(8'h80, 1'b0);
      check(bdm_act, 8'h01);
      rd_chk(PROTECT_ADDR, 8'h01);
      wr(PROTECT_ADDR, 8'h5A, 1'b0);
      rd_chk(PROTECT_ADDR, 8'h01);
      wr(PROTECT_ADDR, 8'h5A, 1'b1);
      rd_chk(PROTECT_ADDR, 8'h5A);
      check(prot, 8'h5A);
      wr(CONFIG_ADDR, 8'hFF, 1'b0);
      rd_chk(CONFIG_ADDR, 8'hE0);
      wr(CONFIG_ADDR, 8'h00, 1'b0);
      rd_chk(16'h1821, READ_UNMAPPED);
      wr(16'hFFB3, 8'h55, 1'b0);
      check({cmd.start, cmd.prot_err}, 8'h01);
      wr(PROTECT_ADDR, 8'h01, 1'b1);
      wr(16'hFFB7, 8'hA6, 1'b0);
      check({cmd.start, cmd.prot_err}, 8'h02);
      check(cmd.data, 8'hA6);
      check(cmd.addr[7:0], 8'hB7);
      check(cmd.addr[15:8], 8'hFF);
      $display("test registers done");
      dbg_req = 1'b1;
      try_key(KEY ^ 64'h1, 1'b0);
      check(secure, 8'h01);
      try_key(KEY, 1'b1);
      check(secure, 8'h01);
      check(dbg_en, 8'h00);
      try_key(KEY, 1'b0);
      check(secure, 8'h00);
      @(negedge CLK);
      check(dbg_en, 8'h01);
      rd_chk(OPTION_STATE_ADDR, 8'h82);
      $display("test backdoor done");
      do_reset(8'h00, 1'b1);
      bdm_req = 1'b1;
      repeat (3) @(negedge CLK);
      bdm_req = 1'b0;
      check(bdm_act, 8'h00);
      try_key(KEY, 1'b0);
      check(secure, 8'h01);
      blank(1'b0);
      check(secure, 8'h01);
      blank(1'b1);
      check(secure, 8'h00);
      $display("test blank check done");
      end_of_test();
   end
endmodule
